// *** rtl/e1rx_pkg.sv ***
// e1rx_pkg: constants, register map and carrier types of the receive serial output
// assumes one 100 MHz clock and a classic wishbone register slave
package e1rx_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ       = 100000000;
    localparam longint BIT_RATE_HZ  = 2048000;
    localparam logic [31:0] NCO_INC = 32'((BIT_RATE_HZ * 2 * (64'h1 << 32)) / CLK_HZ);
    localparam int     BITS_PER_TS  = 8;
    localparam int     SLOTS        = 32;
    localparam int     REF_DIV      = 256;
    localparam logic [7:0] POS_RESET = 8'hFF;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADR_MODE   = 4'h0;
    localparam logic [3:0] ADR_PULSE  = 4'h4;
    localparam logic [3:0] ADR_OPTS   = 4'h8;
    localparam logic [3:0] ADR_STATUS = 4'hC;
    localparam int B_DOUBLE   = 2;
    localparam int B_FE       = 3;
    localparam int B_DE       = 4;
    localparam int B_SLAVE    = 5;
    localparam int B_EXTSIG   = 6;
    localparam int B_ALT      = 0;
    localparam int B_CMF      = 1;
    localparam int B_SMF      = 2;
    localparam int B_SEL3     = 3;
    localparam int B_FRAME_PULSE_MODE   = 5;
    localparam int B_FRAME_PULSE_INVERT    = 6;
    localparam int B_EDGECH   = 0;
    localparam int B_REFSEL   = 1;
    localparam int B_AIS      = 2;
    localparam int B_SRC_A    = 3;
    localparam int B_SRC_B    = 4;
    localparam logic [6:0] MODE_RESET  = 7'h20;
    localparam logic [6:0] PULSE_RESET = 7'h00;
    localparam logic [6:0] OPTS_RESET  = 7'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] data;
        logic [3:0] abcd;
        logic       smf_first;
        logic       cmf_first;
        logic       oosm;
    } e1rx_slot_t;

    typedef struct packed {
        logic [6:0] mode;
        logic [6:0] pulse;
        logic [6:0] opts;
    } e1rx_cfg_t;

endpackage

// *** rtl/e1rx_sync_edge.sv ***
// e1rx_sync_edge: two flop synchroniser with rise and fall detect
// assumes an asynchronous pin level on din
`timescale 1ns/1ps
module e1rx_sync_edge (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~last_reg;
    assign fall  = ~sync_reg & last_reg;
endmodule

// *** rtl/e1rx_serial_out.sv ***
// e1rx_serial_out: per framer receive serial output toward the backplane
// assumes slot data from framer logic on clk, pins sampled through synchronisers
`timescale 1ns/1ps
module e1rx_serial_out
    import e1rx_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sys_common_clock,
    input  wire logic        sys_common_frame_pulse,
    input  wire logic        recovered_line_clock,
    input  e1rx_slot_t       slot_in,
    output logic [4:0]       slot_fetch,
    output logic             rx_serial_data_out,
    output logic             frame_pulse_out,
    output logic             multi_function_out,
    output logic             framer_output_clock
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic bit_of(input logic [7:0] b, input logic [2:0] idx);
        bit_of = b[3'(7 - idx)];
    endfunction

    function automatic logic pick_edge(input logic sel, input logic r, input logic f);
        pick_edge = sel ? f : r;
    endfunction

    // ------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------
    e1rx_cfg_t  cfg_reg;
    logic       ack_reg;
    logic [31:0] rdat_reg;
    logic [7:0] pos_reg;
    logic       oosm_reg;

    wire req     = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire wr_lane = req & wb_we_i & wb_sel_i[0];
    wire [31:0] rd_mux = (wb_adr_i == ADR_MODE)   ? {25'h0, cfg_reg.mode} :
                         (wb_adr_i == ADR_PULSE)  ? {25'h0, cfg_reg.pulse} :
                         (wb_adr_i == ADR_OPTS)   ? {25'h0, cfg_reg.opts} :
                         (wb_adr_i == ADR_STATUS) ? {23'h0, oosm_reg, pos_reg} : 32'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_reg  <= '{mode: MODE_RESET, pulse: PULSE_RESET, opts: OPTS_RESET};
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0;
        end else begin
            ack_reg <= req;
            if (req) rdat_reg <= wb_we_i ? 32'h0 : rd_mux;
            if (wr_lane && wb_adr_i == ADR_MODE)  cfg_reg.mode  <= wb_dat_i[6:0];
            if (wr_lane && wb_adr_i == ADR_PULSE) cfg_reg.pulse <= wb_dat_i[6:0];
            if (wr_lane && wb_adr_i == ADR_OPTS)  cfg_reg.opts  <= wb_dat_i[6:0];
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    wire dbl_rate = cfg_reg.mode[B_DOUBLE];
    wire fe_sel   = cfg_reg.mode[B_FE];
    wire de_sel   = cfg_reg.mode[B_DE];
    wire slave    = cfg_reg.mode[B_SLAVE];
    wire ext_sig  = cfg_reg.mode[B_EXTSIG];
    wire fp_mode  = cfg_reg.pulse[B_FRAME_PULSE_MODE];
    wire fp_inv   = cfg_reg.pulse[B_FRAME_PULSE_INVERT];
    wire edge_ch  = cfg_reg.opts[B_EDGECH];
    wire src_a    = cfg_reg.opts[B_SRC_A];
    wire src_b    = cfg_reg.opts[B_SRC_B];

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic cc_lvl, cc_rise, cc_fall, cfp_lvl, lc_lvl, lc_rise;

    e1rx_sync_edge u_sync_cclk (.clk(clk), .rst(rst), .din(sys_common_clock),
                                .level(cc_lvl), .rise(cc_rise), .fall(cc_fall));
    e1rx_sync_edge u_sync_cfp  (.clk(clk), .rst(rst), .din(sys_common_frame_pulse),
                                .level(cfp_lvl), .rise(), .fall());
    e1rx_sync_edge u_sync_lclk (.clk(clk), .rst(rst), .din(recovered_line_clock),
                                .level(lc_lvl), .rise(lc_rise), .fall());

    // ------------------------------------------------------------
    // own output clock, continuous 2.048 MHz
    // ------------------------------------------------------------
    logic [31:0] nco_reg;
    logic        mclk_reg;
    wire  [32:0] nco_sum = {1'b0, nco_reg} + {1'b0, NCO_INC};
    wire         m_rise  = nco_sum[32] & ~mclk_reg;
    wire         m_fall  = nco_sum[32] & mclk_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            nco_reg  <= 32'h0;
            mclk_reg <= 1'b0;
        end else begin
            nco_reg <= nco_sum[31:0];
            if (nco_sum[32]) mclk_reg <= ~mclk_reg;
        end
    end

    // ------------------------------------------------------------
    // active edge selection
    // ------------------------------------------------------------
    logic phase_reg;
    wire  any_rise = slave ? cc_rise : m_rise;
    wire  any_fall = slave ? cc_fall : m_fall;
    wire  fe_edge  = pick_edge(fe_sel, any_rise, any_fall);
    wire  de_edge  = pick_edge(de_sel, any_rise, any_fall);
    wire  dbl      = slave & dbl_rate;
    wire  same     = de_sel == fe_sel;
    wire  first_fe = ~dbl | ~phase_reg;
    // equal selects ignore the edge choice, else it picks half of the bit
    wire  data_evt = de_edge & (~dbl | (same ? ~phase_reg : (~phase_reg == edge_ch)));
    wire  fp_evt   = fe_edge & (~dbl | (same ? ~phase_reg : (phase_reg == edge_ch)));
    wire  smp_evt  = slave & fe_edge & first_fe;
    wire  cfp_val  = cfp_lvl ^ fp_inv;
    wire  align_set = smp_evt & fp_mode & cfp_val;

    always_ff @(posedge clk) begin
        if (rst) phase_reg <= 1'b0;
        else if (align_set) phase_reg <= 1'b1;
        else if (dbl && fe_edge) phase_reg <= ~phase_reg;
    end

    // ------------------------------------------------------------
    // bit and time slot counter
    // ------------------------------------------------------------
    logic       align_reg;
    logic [7:0] byte_reg;
    logic [7:0] sig_reg;
    wire  [7:0] next_pos  = align_reg ? 8'h00 : 8'(pos_reg + 8'h01);
    wire  [2:0] next_bit  = next_pos[2:0];
    wire  [3:0] abcd_eff  = (slot_in.oosm & cfg_reg.opts[B_AIS]) ? 4'hF : slot_in.abcd;
    wire  [7:0] sig_byte  = {4'h0, abcd_eff};
    assign slot_fetch = next_pos[7:3];

    logic sd_reg;
    logic sig_out_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            pos_reg     <= POS_RESET;
            align_reg   <= 1'b0;
            byte_reg    <= 8'h00;
            sig_reg     <= 8'h00;
            sd_reg      <= 1'b0;
            sig_out_reg <= 1'b0;
            oosm_reg    <= 1'b0;
        end else begin
            if (align_set) align_reg <= 1'b1;
            else if (data_evt) align_reg <= 1'b0;
            if (data_evt) begin
                pos_reg <= next_pos;
                if (next_bit == 3'h0) begin
                    byte_reg    <= slot_in.data;
                    sig_reg     <= sig_byte;
                    oosm_reg    <= slot_in.oosm;
                    sd_reg      <= bit_of(slot_in.data, 3'h0);
                    sig_out_reg <= bit_of(sig_byte, 3'h0);
                end else begin
                    sd_reg      <= bit_of(byte_reg, next_bit);
                    sig_out_reg <= bit_of(sig_reg, next_bit);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // frame pulse output
    // ------------------------------------------------------------
    logic fp_reg;
    wire  frame_start = next_pos == 8'h00;
    wire  any_mf_sel  = cfg_reg.pulse[B_SMF] | cfg_reg.pulse[B_CMF] | cfg_reg.pulse[B_ALT];
    wire  mf_hit      = cfg_reg.pulse[B_ALT] ? (slot_in.smf_first | slot_in.cmf_first) :
                        cfg_reg.pulse[B_SMF] ? slot_in.smf_first :
                        cfg_reg.pulse[B_CMF] ? slot_in.cmf_first : 1'b1;
    wire  mark        = frame_start & ((~fp_mode | ~any_mf_sel) | mf_hit);
    wire  fp_next     = src_a ? (mark ^ fp_inv) :
                        src_b ? cfp_lvl : 1'b0;

    always_ff @(posedge clk) begin
        if (rst) fp_reg <= 1'b0;
        else if (fp_evt) fp_reg <= fp_next;
    end

    // ------------------------------------------------------------
    // reference clock and shared pin
    // ------------------------------------------------------------
    logic [6:0] ref_cnt_reg;
    logic       ref8k_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_cnt_reg <= 7'h00;
            ref8k_reg   <= 1'b0;
        end else if (lc_rise) begin
            ref_cnt_reg <= ref_cnt_reg + 7'h01;
            if (ref_cnt_reg == 7'(REF_DIV / 2 - 1)) ref8k_reg <= ~ref8k_reg;
        end
    end
    wire ref_clk = cfg_reg.opts[B_REFSEL] ? ref8k_reg : lc_lvl;

    assign rx_serial_data_out  = sd_reg;
    assign frame_pulse_out     = fp_reg;
    assign framer_output_clock = mclk_reg;
    assign multi_function_out  = ~slave ? mclk_reg : ext_sig ? sig_out_reg : ref_clk;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_last_bit;
        data_evt && !align_reg && pos_reg == 8'h FF;
    endsequence

    a_data_edge_only: assert property ($changed(sd_reg) |-> $past(data_evt))
        else $error("data changed off its edge");
    a_fp_edge_only: assert property ($changed(fp_reg) |-> $past(fp_evt))
        else $error("frame pulse changed off its edge");
    a_first_bit_msb: assert property (data_evt && next_bit == 3'h0 |=> sd_reg == $past(slot_in.data[7]))
        else $error("slot did not start with bit 1");
    sequence s_forced_slot;
        data_evt && next_bit == 3'h0 && slot_in.oosm && cfg_reg.opts[B_AIS];
    endsequence

    a_sig_ais_ones: assert property (s_forced_slot |=> sig_reg[3:0] == 4'hF)
        else $error("signaling not forced to ones");
    a_fp_zero_src: assert property (!src_a && !src_b && fp_evt |=> !fp_reg)
        else $error("frame pulse not zero");
    a_fp_ignored: assert property (!fp_mode |=> !$rose(align_reg))
        else $error("common pulse not ignored");
    a_align_zero: assert property (align_reg && data_evt |=> pos_reg == 8'h00)
        else $error("realign missed");
    a_frame_wrap: assert property (s_last_bit |=> pos_reg == 8'h00 ##0 slot_fetch == 5'h00)
        else $error("counter did not wrap");
    a_master_pin: assert property (!slave |-> multi_function_out == mclk_reg)
        else $error("shared pin not own clock");
    a_own_clock_period: assert property ($rose(mclk_reg) |-> ##[48:49] $rose(mclk_reg))
        else $error("own clock period wrong");
    a_master_data_edge: assert property (!slave && !de_sel && data_evt |=> $rose(mclk_reg))
        else $error("master data off its clock edge");
    a_ref_divide: assert property ($changed(ref8k_reg) |-> $past(lc_rise) && $past(ref_cnt_reg) == 7'h7F)
        else $error("reference divider toggled early");
    a_basic_only: assert property (src_a && !fp_mode && fp_evt |=> fp_reg == ($past(frame_start) ^ $past(fp_inv)))
        else $error("pulse not basic frame only");
    a_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
endmodule

// *** verif/e1rx_backplane_model.sv ***
// e1rx_backplane_model: system side tdm bus, common clock, frame pulse, line clock
// assumes 100 MHz clk; common clock period 20 clk, line clock period 50 clk
`timescale 1ns/1ps
module e1rx_backplane_model (
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  inv,
    output logic       sys_common_clock,
    output logic       sys_common_frame_pulse,
    output logic       recovered_line_clock,
    output logic [7:0] bit_idx,
    output logic       mid
);
    logic [4:0] hc;
    logic [4:0] lc;
    always_ff @(posedge clk) begin
        mid <= 1'b0;
        if (rst) begin
            hc                     <= 5'h00;
            lc                     <= 5'h00;
            bit_idx                <= 8'hFE;
            sys_common_clock       <= 1'b0;
            sys_common_frame_pulse <= inv;
            recovered_line_clock   <= 1'b0;
        end else begin
            hc <= (hc == 5'h09) ? 5'h00 : hc + 5'h01;
            lc <= (lc == 5'h18) ? 5'h00 : lc + 5'h01;
            if (lc == 5'h18) begin
                recovered_line_clock <= ~recovered_line_clock;
            end
            if (hc == 5'h09) begin
                sys_common_clock <= ~sys_common_clock;
                if (!sys_common_clock) begin
                    bit_idx <= bit_idx + 8'h01;
                end else begin
                    mid                    <= 1'b1;
                    // valid level across the edge that opens the bit before slot 0 bit 1
                    sys_common_frame_pulse <= (bit_idx == 8'hFE) ^ inv;
                end
            end
        end
    end
endmodule

// *** verif/e1rx_serial_out_tb_top.sv ***
// e1rx_serial_out_tb_top: self checking bench of the receive serial output
// assumes the backplane model for pin timing and a random table of slot contents
`timescale 1ns/1ps
module e1rx_serial_out_tb_top;
    import e1rx_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'h0;
    logic        we = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        inv = 1'b0;
    logic        oosm_drv = 1'b0;
    logic        ais = 1'b0;
    logic        sig_on = 1'b0;
    logic        pen = 1'b1;
    logic        chk_on = 1'b0;
    logic        smf = 1'b0;
    logic [31:0] rdat, q;
    logic        ack, cck, cfp, lck, sdo, fpo, mfo, oclk, mid;
    logic [4:0]  fetch;
    logic [7:0]  bi;
    logic [7:0]  tbl [32];
    logic [3:0]  sig [32];
    e1rx_slot_t  slot;
    int          fails = 0;
    int          n_compared = 0;
    int          cycles = 0;

    assign slot = '{data: tbl[fetch], abcd: sig[fetch], smf_first: smf, cmf_first: 1'b0, oosm: oosm_drv};
    initial begin
        forever #5 clk = ~clk;
    end

    e1rx_serial_out dut_u (
        .clk                    (clk),
        .rst                    (rst),
        .wb_adr_i               (adr),
        .wb_dat_i               (wdat),
        .wb_sel_i               (sel),
        .wb_we_i                (we),
        .wb_cyc_i               (cyc),
        .wb_stb_i               (stb),
        .wb_dat_o               (rdat),
        .wb_ack_o               (ack),
        .sys_common_clock       (cck),
        .sys_common_frame_pulse (cfp),
        .recovered_line_clock   (lck),
        .slot_in                (slot),
        .slot_fetch             (fetch),
        .rx_serial_data_out     (sdo),
        .frame_pulse_out        (fpo),
        .multi_function_out     (mfo),
        .framer_output_clock    (oclk)
    );
    e1rx_backplane_model bp_u (
        .clk                    (clk),
        .rst                    (rst),
        .inv                    (inv),
        .sys_common_clock       (cck),
        .sys_common_frame_pulse (cfp),
        .recovered_line_clock   (lck),
        .bit_idx                (bi),
        .mid                    (mid)
    );

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic pulse_exp(input logic [7:0] b);
        return ((b == 8'h00) & pen) ^ inv;
    endfunction
    function automatic logic sig_exp(input logic [7:0] b);
        if (b[2:0] < 3'h4) return 1'b0;
        return (ais & oosm_drv) ? 1'b1 : sig[b[7:3]][3'h7 - b[2:0]];
    endfunction
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 95000) begin
            fails++;
            wrap_up();
        end
        if (chk_on && mid) begin
            chk(32'(sdo), 32'(tbl[bi[7:3]][3'h7 - bi[2:0]]));
            chk(32'(fpo), 32'(pulse_exp(bi)));
            if (sig_on) chk(32'(mfo), 32'(sig_exp(bi)));
        end
    end

    // ------------------------------------------------------------
    // bus and stimulus tasks
    // ------------------------------------------------------------
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        adr  <= a;
        we   <= w;
        wdat <= d;
        sel  <= s;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic cfg(input logic [31:0] m, input logic [31:0] p, input logic [31:0] o);
        wb(ADR_MODE, 1'b1, m, 4'hF);
        wb(ADR_PULSE, 1'b1, p, 4'hF);
        wb(ADR_OPTS, 1'b1, o, 4'hF);
    endtask
    task automatic run2;
        repeat (5200) @(posedge clk);
        chk_on <= 1'b1;
        repeat (5120) @(posedge clk);
        chk_on <= 1'b0;
    endtask
    task automatic cnt(input logic w, input int n_cyc, input int lo, input int hi);
        int n;
        logic p;
        logic c;
        n = 0;
        p = w ? mfo : oclk;
        repeat (n_cyc) begin
            @(posedge clk);
            c = w ? mfo : oclk;
            n += (c !== p);
            p = c;
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] v;
        void'($urandom(81));
        for (int i = 0; i < 32; i++) begin
            tbl[i] = 8'($urandom);
            sig[i] = 4'($urandom);
        end
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wb(ADR_MODE, 1'b0, 32'h0, 4'hF);
        chk(q, 32'(MODE_RESET));
        wb(ADR_PULSE, 1'b0, 32'h0, 4'hF);
        chk(q, 32'(PULSE_RESET));
        v = $urandom;
        wb(ADR_OPTS, 1'b1, v, 4'hF);
        wb(ADR_OPTS, 1'b1, ~v, 4'hE);
        wb(ADR_OPTS, 1'b0, 32'h0, 4'hF);
        chk(q, {25'h0, v[6:0]});
        wb(4'h2, 1'b1, v, 4'hF);
        wb(4'h2, 1'b0, 32'h0, 4'hF);
        chk(q, 32'h0);
        // slave reference mode, rising edges alike in every framer
        cfg(32'h20, 32'h20, 32'h08);
        run2();
        cnt(1'b1, 5000, 196, 204);
        inv <= 1'b1;
        cfg(32'h20, 32'h60, 32'h0A);
        run2();
        cnt(1'b1, 12800, 1, 3);
        // external signaling, forced ones then random loss state
        inv    <= 1'b0;
        sig_on <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            oosm_drv <= (i == 0) | 1'($urandom);
            ais      <= (i == 0) | 1'($urandom);
            @(posedge clk);
            cfg(32'h60, 32'h20, {27'h0, 2'h1, ais, 2'h0});
            run2();
            wb(ADR_STATUS, 1'b0, 32'h0, 4'hF);
            chk(32'(q[8]), 32'(oosm_drv));
        end
        // signaling multiframe mark off, then flagged by the slot source
        sig_on <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            pen <= (i == 1);
            smf <= (i == 1);
            cfg(32'h20, 32'h24, 32'h08);
            run2();
        end
        // master mode, frame pulse mode cleared, multiframe select left set
        cfg(32'h00, 32'h04, 32'h08);
        cnt(1'b0, 4883, 198, 202);
        wrap_up();
    end
endmodule
